// ==== include/cbt_pkg.sv ====
// Constants, types and helpers shared by the CAN bit-timing blocks.
package cbt_pkg;

  // ------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned BUS_W     = 32;
  localparam int unsigned CFG_W     = 16;

  // ------------------------------------------------------------------
  // Register map and layout
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CFG2_OFFSET = 12'h000;
  localparam logic [CFG_W-1:0]  CFG2_RESET  = 16'h0000;
  localparam logic [CFG_W-1:0]  CFG2_WMASK  = 16'h47FF;
  localparam int unsigned WAKE_BIT    = 14;
  localparam int unsigned PH2_LSB     = 8;
  localparam int unsigned PH2_SEL_BIT = 7;
  localparam int unsigned TRIPLE_BIT  = 6;
  localparam int unsigned PH1_LSB     = 3;
  localparam int unsigned PROP_LSB    = 0;
  localparam int unsigned FIELD_W     = 3;
  localparam int unsigned LEN_W       = 4;

  // ------------------------------------------------------------------
  // Timing in time quanta
  // ------------------------------------------------------------------
  localparam logic [LEN_W-1:0] SYNC_LEN          = 4'h1;
  localparam logic [LEN_W-1:0] PROC_TIME_DEFAULT = 4'h2;

  // ------------------------------------------------------------------
  // Bus encodings
  // ------------------------------------------------------------------
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;

  typedef enum logic [1:0] {
    CBT_SYNC,
    CBT_PROP,
    CBT_PH1,
    CBT_PH2
  } cbt_seg_e;

  // A 3-bit length code stands for code + 1 quanta.
  function automatic logic [LEN_W-1:0] seg_len(
    input logic [FIELD_W-1:0] code
  );
    seg_len = {1'b0, code} + 4'h1;
  endfunction : seg_len

  function automatic logic [LEN_W-1:0] max_len(
    input logic [LEN_W-1:0] a,
    input logic [LEN_W-1:0] b
  );
    max_len = (a > b) ? a : b;
  endfunction : max_len

  // Write mask over the two low byte lanes that hold the register.
  function automatic logic [CFG_W-1:0] lane_mask(
    input logic [2:0] size,
    input logic [1:0] addr
  );
    logic [CFG_W-1:0] m;
    m = 16'h0000;
    if (size == HSIZE_BYTE) begin
      if (addr == 2'h0) m = 16'h00FF;
      if (addr == 2'h1) m = 16'hFF00;
    end else if (size == HSIZE_HALF) begin
      if (addr[1] == 1'b0) m = 16'hFFFF;
    end else begin
      m = 16'hFFFF;
    end
    lane_mask = m;
  endfunction : lane_mask

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority

endpackage : cbt_pkg

// ==== rtl/cbt_ahb_slave.sv ====
// AHB-Lite slave front end for the bit-timing configuration register.
`timescale 1ns/10ps
module cbt_ahb_slave (
  // Clock, reset and enable
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  wire logic                       en_i,
  // AHB-Lite
  input  wire logic                       hsel_i,
  input  wire logic [cbt_pkg::ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]                 htrans_i,
  input  wire logic                       hwrite_i,
  input  wire logic [2:0]                 hsize_i,
  input  wire logic [cbt_pkg::BUS_W-1:0]  hwdata_i,
  input  wire logic                       hready_i,
  output logic                            hreadyout_o,
  output logic                            hresp_o,
  output logic [cbt_pkg::BUS_W-1:0]       hrdata_o,
  // Register side
  input  wire logic [cbt_pkg::CFG_W-1:0]  rd_data_i,
  output logic                            wr_en_o,
  output logic [cbt_pkg::CFG_W-1:0]       wr_data_o,
  output logic [cbt_pkg::CFG_W-1:0]       wr_mask_o
);
  import cbt_pkg::*;

  logic             wr_pend;
  logic [CFG_W-1:0] mask_q;
  wire  addr_ok  = (haddr_i[ADDR_W-1:2] == CFG2_OFFSET[ADDR_W-1:2]);
  wire  take     = hsel_i & htrans_i[1] & hready_i & en_i;
  wire  take_wr  = take & hwrite_i & addr_ok;
  wire  take_rd  = take & ~hwrite_i;

  // A frozen block stretches the transfer rather than dropping it.
  assign hreadyout_o = en_i;
  assign hresp_o     = 1'b0;
  assign wr_en_o     = wr_pend & en_i;
  assign wr_data_o   = hwdata_i[CFG_W-1:0];
  assign wr_mask_o   = mask_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend  <= 1'b0;
      mask_q   <= 16'h0000;
      hrdata_o <= 32'h0000_0000;
    end else if (en_i) begin
      wr_pend <= take_wr;
      mask_q  <= lane_mask(hsize_i, haddr_i[1:0]);
      if (take_rd) begin
        hrdata_o <= addr_ok ? {16'h0000, rd_data_i} : 32'h0000_0000;
      end
    end
  end

endmodule : cbt_ahb_slave

// ==== rtl/cbt_sampler.sv ====
// Bus line sampler taking one or three samples at the sample point.
`timescale 1ns/10ps
module cbt_sampler (
  // Clock, reset and enable
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  // Timing strobes
  input  wire logic tq_tick_i,
  input  wire logic sample_pt_i,
  input  wire logic triple_i,
  // Bus line
  input  wire logic rx_i,
  output logic      bit_o,
  output logic      bit_valid_o
);
  import cbt_pkg::*;

  logic [1:0] hist;
  wire  [2:0] window = {hist, rx_i};
  wire  take         = en_i & tq_tick_i & sample_pt_i;
  // Triple mode votes over the two preceding quanta and this one.
  wire  next_bit     = triple_i ? majority(window) : rx_i;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hist        <= 2'b11;
      bit_o       <= 1'b1;
      bit_valid_o <= 1'b0;
    end else if (en_i) begin
      if (tq_tick_i) hist <= {hist[0], rx_i};
      if (take) bit_o <= next_bit;
      bit_valid_o <= take;
    end
  end

  chk_single_sample: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (take && !triple_i) |=> (bit_valid_o && bit_o == $past(rx_i)))
    else $error("single sample does not follow the line");

  chk_triple_vote: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (take && triple_i) |=>
      (bit_o == majority({$past(hist), $past(rx_i)})))
    else $error("triple sample vote is wrong");

  cov_triple_split: cover property (
    @(posedge mclk_i) disable iff (rst_i)
    take && triple_i && (window == 3'b101));

endmodule : cbt_sampler

// ==== rtl/cbt_timing.sv ====
// CAN bit-timing configuration register two and its bit-segment engine.
//
// Operation
// - Phase two length code gives code plus one quanta, one to eight.
// - Phase one length code gives code plus one quanta, up to eight.
// - Select bit set: programmed phase two length is used directly.
// - Select bit clear: phase two is max of phase one and processing time.
// - Sample-count bit set takes three samples, clear takes one.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module cbt_timing #(
  parameter logic [cbt_pkg::LEN_W-1:0] PROC_TIME_QUANTA =
    cbt_pkg::PROC_TIME_DEFAULT
) (
  // Clock, reset and enable
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  wire logic                       en_i,
  // AHB-Lite register bus
  input  wire logic                       hsel_i,
  input  wire logic [cbt_pkg::ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]                 htrans_i,
  input  wire logic                       hwrite_i,
  input  wire logic [2:0]                 hsize_i,
  input  wire logic [cbt_pkg::BUS_W-1:0]  hwdata_i,
  input  wire logic                       hready_i,
  output logic                            hreadyout_o,
  output logic                            hresp_o,
  output logic [cbt_pkg::BUS_W-1:0]       hrdata_o,
  // Time quantum and bus line
  input  wire logic                       tq_tick_i,
  input  wire logic                       rx_i,
  // Bit timing results
  output logic [cbt_pkg::LEN_W-1:0]       propagation_length_o,
  output logic [cbt_pkg::LEN_W-1:0]       phase_one_length_o,
  output logic [cbt_pkg::LEN_W-1:0]       phase_two_length_o,
  output logic                            triple_sample_enable_o,
  output logic                            wake_line_filter_enable_o,
  output logic                            sample_point_o,
  output logic                            bit_end_o,
  output logic                            rx_bit_o,
  output logic                            rx_bit_valid_o
);
  import cbt_pkg::*;

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  logic [CFG_W-1:0] cfg;
  logic [CFG_W-1:0] next_cfg;
  logic             wr_en;
  logic [CFG_W-1:0] wr_data;
  logic [CFG_W-1:0] wr_mask;

  cbt_ahb_slave u_bus (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .en_i        (en_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .hrdata_o    (hrdata_o),
    .rd_data_i   (next_cfg),
    .wr_en_o     (wr_en),
    .wr_data_o   (wr_data),
    .wr_mask_o   (wr_mask)
  );

  // Reads see the value after a write still in its data phase, so a
  // write followed at once by a read of the same word is never stale.
  wire [CFG_W-1:0] lane_sel = wr_mask & CFG2_WMASK;
  assign next_cfg = wr_en ? ((cfg & ~lane_sel) | (wr_data & lane_sel))
                          : cfg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg <= CFG2_RESET;
    end else if (en_i) begin
      cfg <= next_cfg;
    end
  end

  // ------------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------------
  wire [FIELD_W-1:0] ph2_code  = cfg[PH2_LSB +: FIELD_W];
  wire [FIELD_W-1:0] ph1_code  = cfg[PH1_LSB +: FIELD_W];
  wire [FIELD_W-1:0] prop_code = cfg[PROP_LSB +: FIELD_W];
  wire               ph2_sel   = cfg[PH2_SEL_BIT];

  wire [LEN_W-1:0] prop_len = seg_len(prop_code);
  wire [LEN_W-1:0] ph1_len  = seg_len(ph1_code);
  wire [LEN_W-1:0] ph2_prog = seg_len(ph2_code);
  // Automatic mode keeps phase two long enough for the controller to
  // finish processing the bit just sampled.
  wire [LEN_W-1:0] ph2_auto = max_len(ph1_len, PROC_TIME_QUANTA);
  wire [LEN_W-1:0] ph2_len  = ph2_sel ? ph2_prog : ph2_auto;

  assign propagation_length_o      = prop_len;
  assign phase_one_length_o        = ph1_len;
  assign phase_two_length_o        = ph2_len;
  assign triple_sample_enable_o    = cfg[TRIPLE_BIT];
  assign wake_line_filter_enable_o = cfg[WAKE_BIT];

  // ------------------------------------------------------------------
  // Segment engine
  // ------------------------------------------------------------------
  cbt_seg_e         seg;
  cbt_seg_e         next_seg;
  logic [LEN_W-1:0] qcnt;
  logic [LEN_W-1:0] cur_len;

  always_comb begin
    cur_len  = SYNC_LEN;
    next_seg = seg;
    unique case (seg)
      CBT_SYNC: begin
        cur_len  = SYNC_LEN;
        next_seg = CBT_PROP;
      end
      CBT_PROP: begin
        cur_len  = prop_len;
        next_seg = CBT_PH1;
      end
      CBT_PH1: begin
        cur_len  = ph1_len;
        next_seg = CBT_PH2;
      end
      CBT_PH2: begin
        cur_len  = ph2_len;
        next_seg = CBT_SYNC;
      end
    endcase
  end

  // The compare is "at least" so that shortening a field while a
  // segment runs ends the segment at once instead of wrapping.
  wire [LEN_W-1:0] qcnt_inc = qcnt + 4'h1;
  wire tick    = en_i & tq_tick_i;
  wire seg_end = tick & (qcnt_inc >= cur_len);

  assign sample_point_o = seg_end & (seg == CBT_PH1);
  assign bit_end_o      = seg_end & (seg == CBT_PH2);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      seg  <= CBT_SYNC;
      qcnt <= 4'h0;
    end else if (tick) begin
      if (seg_end) begin
        seg  <= next_seg;
        qcnt <= 4'h0;
      end else begin
        qcnt <= qcnt_inc;
      end
    end
  end

  // ------------------------------------------------------------------
  // Sampling
  // ------------------------------------------------------------------
  cbt_sampler u_sample (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .en_i        (en_i),
    .tq_tick_i   (tq_tick_i),
    .sample_pt_i (sample_point_o),
    .triple_i    (cfg[TRIPLE_BIT]),
    .rx_i        (rx_i),
    .bit_o       (rx_bit_o),
    .bit_valid_o (rx_bit_valid_o)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  wire full_wr = wr_en && (wr_mask == 16'hFFFF);

  chk_ph2_programmed: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (full_wr && wr_data[PH2_SEL_BIT]) |=>
      (phase_two_length_o ==
       {1'b0, $past(wr_data[PH2_LSB +: FIELD_W])} + 4'h1))
    else $error("phase two length differs from code plus one");

  chk_ph2_direct: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ph2_sel && ph2_code == 3'h7) |-> (phase_two_length_o == 4'h8))
    else $error("programmed phase two not used directly");

  chk_ph1_length: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    full_wr |=>
      (phase_one_length_o ==
       {1'b0, $past(wr_data[PH1_LSB +: FIELD_W])} + 4'h1))
    else $error("phase one length differs from code plus one");

  chk_prop_length: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    full_wr |=>
      (propagation_length_o ==
       {1'b0, $past(wr_data[PROP_LSB +: FIELD_W])} + 4'h1))
    else $error("propagation length differs from code plus one");

  chk_ph2_auto: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !ph2_sel |->
      (phase_two_length_o >= phase_one_length_o) &&
      (phase_two_length_o >= PROC_TIME_QUANTA) &&
      ((phase_two_length_o == phase_one_length_o) ||
       (phase_two_length_o == PROC_TIME_QUANTA)))
    else $error("automatic phase two is not the greater length");

  chk_sample_gap: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (sample_point_o && tq_tick_i) |=>
      (seg == CBT_PH2 && qcnt == 4'h0))
    else $error("sample point does not open phase two");

  cov_auto_proc: cover property (
    @(posedge mclk_i) disable iff (rst_i)
    !ph2_sel && (PROC_TIME_QUANTA > ph1_len) && bit_end_o);

  cov_full_bit: cover property (
    @(posedge mclk_i) disable iff (rst_i)
    sample_point_o ##[1:64] bit_end_o);

  cov_triple_point: cover property (
    @(posedge mclk_i) disable iff (rst_i)
    sample_point_o && triple_sample_enable_o);

  cov_wait_state: cover property (
    @(posedge mclk_i) disable iff (rst_i)
    hsel_i && htrans_i[1] && !hreadyout_o);

  // ------------------------------------------------------------------
  // Bus and engine checks
  // ------------------------------------------------------------------
  // A read is taken on the same terms as in the bus front end; between
  // such edges the read data must stand for the master.
  wire rd_take = hsel_i & htrans_i[1] & hready_i & en_i & ~hwrite_i;

  chk_bus_okay: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    hresp_o == 1'b0)
    else $error("register bus answered with an error");

  chk_read_upper: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    hrdata_o[BUS_W-1:CFG_W] == 16'h0000)
    else $error("upper read data is not zero");

  chk_read_stands: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !rd_take |=> $stable(hrdata_o))
    else $error("read data changed without a read");

  chk_reserved_zero: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (cfg & ~CFG2_WMASK) == 16'h0000)
    else $error("reserved register bits are not zero");

  chk_write_lands: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    full_wr |=> (cfg == ($past(wr_data) & CFG2_WMASK)))
    else $error("word write did not land in the register");

  chk_frozen_state: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !en_i |=> ($stable(cfg) && $stable(seg) && $stable(qcnt)))
    else $error("state moved while the block was frozen");

  chk_strobes_apart: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !(sample_point_o && bit_end_o))
    else $error("sample point and bit end in one cycle");

  chk_count_bound: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    qcnt <= 4'h7)
    else $error("quantum count passed the longest segment");

  chk_sync_single: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (tick && seg == CBT_SYNC) |-> seg_end)
    else $error("sync segment is longer than one quantum");

  chk_prop_opens: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (seg_end && seg == CBT_SYNC) |=> (seg == CBT_PROP && qcnt == 4'h0))
    else $error("propagation segment does not follow sync");

  chk_bit_wraps: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    bit_end_o |=> (seg == CBT_SYNC && qcnt == 4'h0))
    else $error("bit end does not return to sync");

  chk_valid_follows: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    sample_point_o |=> rx_bit_valid_o)
    else $error("no sampled bit after the sample point");

endmodule : cbt_timing

// ==== verification/cbt_line_model.sv ====
// Far side model: time quantum source and a CAN receive line.
`timescale 1ns/10ps
module cbt_line_model (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // Scenario control and observed strobe
  input  wire logic glitch_i,
  input  wire logic sample_point_i,
  // Line side
  output logic      tq_tick_o,
  output logic      rx_o
);
  // ------------------------------------------------------------------
  // Quantum source
  // ------------------------------------------------------------------
  // One quantum per clock keeps the bit periods short and exactly countable.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tq_tick_o <= 1'b0;
    end else begin
      tq_tick_o <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Receive line
  // ------------------------------------------------------------------
  // A short noise spike lands exactly on the sample point when asked for.
  // The recessive level is held at every other quantum.
  assign rx_o = glitch_i ? ~sample_point_i : 1'b1;
endmodule : cbt_line_model

// ==== verification/can_bit_timing_config_two_tb.sv ====
// Self-checking bench for the bit-timing configuration register two.
`timescale 1ns/10ps
module can_bit_timing_config_two_tb;
  import cbt_pkg::*;
  localparam logic [LEN_W-1:0] PROC_TIME = 4'h3;
  logic              mclk_i = 1'b0;
  logic              rst_i  = 1'b1;
  logic              en_i   = 1'b1;
  logic              hsel_i = 1'b1;
  logic              hwrite_i = 1'b0;
  logic              glitch = 1'b0;
  logic [ADDR_W-1:0] haddr_i = '0;
  logic [1:0]        htrans_i = 2'h0;
  logic [2:0]        hsize_i = 3'h2;
  logic [BUS_W-1:0]  hwdata_i = '0;
  logic              hreadyout_o, hresp_o, tq_tick, rx;
  logic [BUS_W-1:0]  hrdata_o;
  logic [LEN_W-1:0]  prop_len, ph1_len, ph2_len;
  logic              triple, wake, spt, bend, rxb, rxv;
  int                n_mismatch = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  int                n;
  int                g;
  logic [15:0]       rdv;
  logic [3:0]        e;

  always #12.5 mclk_i = ~mclk_i;

  cbt_timing #(.PROC_TIME_QUANTA(PROC_TIME)) i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .en_i(en_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .tq_tick_i(tq_tick), .rx_i(rx), .propagation_length_o(prop_len),
    .phase_one_length_o(ph1_len), .phase_two_length_o(ph2_len),
    .triple_sample_enable_o(triple), .wake_line_filter_enable_o(wake),
    .sample_point_o(spt), .bit_end_o(bend), .rx_bit_o(rxb),
    .rx_bit_valid_o(rxv));

  cbt_line_model i_line (
    .mclk_i(mclk_i), .rst_i(rst_i), .glitch_i(glitch),
    .sample_point_i(spt), .tq_tick_o(tq_tick), .rx_o(rx));

  // ------------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // A hang anywhere ends the run well past the expected length.
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------------
  // Bus, bit timing and sampling tasks
  // ------------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [15:0] d);
    @(posedge mclk_i);
    haddr_i  <= a;
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= {16'h0000, d};
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rdv = hrdata_o[15:0];
    chk("bus response", {15'h0, hresp_o}, 16'h0000);
    if (!wr) chk("upper read data", hrdata_o[31:16], 16'h0000);
    if (wr) @(posedge mclk_i);
  endtask : ahb

  task automatic bit_cycles(output int cnt, output int gap);
    cnt = 0;
    gap = 0;
    do @(posedge mclk_i); while (bend !== 1'b1);
    do @(posedge mclk_i); while (bend !== 1'b1);
    do begin
      @(posedge mclk_i);
      cnt++;
      gap = (spt === 1'b1) ? 0 : gap + 1;
    end while (bend !== 1'b1);
  endtask : bit_cycles

  task automatic sample_seen(input logic exp);
    repeat (2) begin
      do @(posedge mclk_i); while (rxv !== 1'b1);
    end
    chk("sampled bit", {15'h0, rxb}, {15'h0, exp});
  endtask : sample_seen

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    ahb(1'b0, 12'h000, 16'h0000);
    chk("reset value", rdv, 16'h0000);
    ahb(1'b1, 12'h000, 16'hFFFF);
    ahb(1'b0, 12'h000, 16'h0000);
    chk("reserved bits", rdv, 16'h47FF);
    chk("wake output", {15'h0, wake}, 16'h0001);
    ahb(1'b1, 12'h004, 16'h1234);
    ahb(1'b0, 12'h004, 16'h0000);
    chk("unmapped read", rdv, 16'h0000);
    ahb(1'b0, 12'h000, 16'h0000);
    chk("unmapped write", rdv, 16'h47FF);
    hsize_i <= HSIZE_BYTE;
    ahb(1'b1, 12'h001, 16'h0000);
    ahb(1'b1, 12'h002, 16'h0000);
    ahb(1'b0, 12'h000, 16'h0000);
    chk("byte lane write", rdv, 16'h00FF);
    hsize_i <= HSIZE_HALF;
    ahb(1'b1, 12'h000, 16'h4100);
    hsize_i <= 3'h2;
    ahb(1'b0, 12'h000, 16'h0000);
    chk("half word write", rdv, 16'h4100);
    for (int c = 0; c < 8; c++) begin
      ahb(1'b1, 12'h000, {5'h00, 3'(7 - c), 2'b10, 3'(c), 3'(c)});
      chk("prop length", {12'h0, prop_len}, 16'(c + 1));
      chk("ph1 length", {12'h0, ph1_len}, 16'(c + 1));
      chk("ph2 programmed", {12'h0, ph2_len}, 16'(8 - c));
      ahb(1'b1, 12'h000, {5'h00, 3'(7 - c), 2'b00, 3'(c), 3'(c)});
      e = (c + 1 > PROC_TIME) ? 4'(c + 1) : PROC_TIME;
      chk("ph2 automatic", {12'h0, ph2_len}, {12'h0, e});
    end
    ahb(1'b1, 12'h000, 16'h0080);
    bit_cycles(n, g);
    chk("short bit", 16'(n), 16'd4);
    chk("short phase two", 16'(g), 16'h0001);
    ahb(1'b1, 12'h000, 16'h0000);
    bit_cycles(n, g);
    chk("auto bit", 16'(n), 16'(3 + PROC_TIME));
    chk("auto phase two", 16'(g), 16'(PROC_TIME));
    ahb(1'b1, 12'h000, 16'h07BF);
    bit_cycles(n, g);
    chk("long bit", 16'(n), 16'd25);
    chk("long phase two", 16'(g), 16'h0008);
    // A write started while frozen must wait, not be lost.
    en_i <= 1'b0;
    fork
      ahb(1'b1, 12'h000, 16'h0080);
      begin
        repeat (3) @(posedge mclk_i);
        chk("frozen ready", {15'h0, hreadyout_o}, 16'h0000);
        chk("frozen strobes", {15'h0, spt | bend}, 16'h0000);
        en_i <= 1'b1;
      end
    join
    ahb(1'b0, 12'h000, 16'h0000);
    chk("write after wait", rdv, 16'h0080);
    glitch <= 1'b1;
    ahb(1'b1, 12'h000, 16'h0080);
    sample_seen(1'b0);
    ahb(1'b1, 12'h000, 16'h00C0);
    chk("triple output", {15'h0, triple}, 16'h0001);
    sample_seen(1'b1);
    report_and_stop();
  end
endmodule : can_bit_timing_config_two_tb
